// [ddim_pkg.sv]
`default_nettype none

package ddim_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam int unsigned REG_AW         = 12;
  localparam logic [11:0] OFS_MODE_ZERO  = 12'h100;
  localparam logic [11:0] OFS_MODE_ONE   = 12'h124;
  localparam logic [11:0] OFS_RANK_BND0  = 12'h180;
  localparam logic [11:0] OFS_RANK_BND1  = 12'h181;
  localparam logic [11:0] OFS_RANK_BND2  = 12'h182;

  localparam int unsigned SCM_LSB        = 4;
  localparam int unsigned SCM_MSB        = 6;
  localparam int unsigned MTYPE_LSB      = 0;
  localparam int unsigned MTYPE_MSB      = 1;
  localparam int unsigned ENH_BIT        = 31;
  localparam logic [1:0]  MTYPE_DDR2     = 2'h2;
  localparam logic [2:0]  SCM_RST        = 3'h0;
  localparam logic [7:0]  RANK_BND_RST   = 8'h00;

  localparam logic [2:0]  SCM_NORMAL     = 3'h0;
  localparam logic [2:0]  SCM_NOP        = 3'h1;
  localparam logic [2:0]  SCM_PREALL     = 3'h2;
  localparam logic [2:0]  SCM_MRS        = 3'h3;
  localparam logic [2:0]  SCM_EMRS       = 3'h4;

  // ---------------------------------------------------------------------------
  // memory command encoding, {ras_n, cas_n, we_n}
  // ---------------------------------------------------------------------------
  localparam int unsigned MA_W           = 14;
  localparam int unsigned BA_W           = 2;
  localparam int unsigned AP_BIT         = 10;
  localparam logic [2:0]  PIN_NOP        = 3'h7;
  localparam logic [2:0]  PIN_PRE        = 3'h2;
  localparam logic [2:0]  PIN_MRS        = 3'h0;
  localparam logic [2:0]  PIN_SRE        = 3'h1;
  localparam logic [BA_W-1:0] BA_MR      = 2'h0;
  localparam logic [BA_W-1:0] BA_EMR1    = 2'h1;

  // host address bit that lands on memory address line 0
  localparam int unsigned STD_MA_LSB     = 3;
  localparam int unsigned ENH_MA_LSB     = 4;

  typedef enum {CMD_NOP, CMD_PREALL, CMD_MRS, CMD_EMRS, CMD_SRE} ddim_cmd_t;
  typedef enum {PW_RUN, PW_FLUSH, PW_SRE, PW_SR, PW_EXIT} ddim_pwr_t;

  // host address to {bank, memory address}
  function automatic logic [BA_W+MA_W-1:0] ddim_map_addr(input logic [31:0] addr, input logic enh);
    logic [31:0] shifted;
    shifted = enh ? (addr >> ENH_MA_LSB) : (addr >> STD_MA_LSB);
    return shifted[BA_W+MA_W-1:0];
  endfunction

endpackage

`default_nettype wire

// [ddim_cmd_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface ddim_cmd_if;
  logic                          valid;
  logic                          ready;
  ddim_pkg::ddim_cmd_t           cmd;
  logic [ddim_pkg::BA_W-1:0]     ba;
  logic [ddim_pkg::MA_W-1:0]     ma;

  modport source  (output valid, output cmd, output ba, output ma, input ready);
  modport issuer  (input valid, input cmd, input ba, input ma, output ready);
endinterface

`default_nettype wire

// [ddim_cmd_out.sv]
`timescale 1ns/1ps
`default_nettype none

module ddim_cmd_out #(
  parameter int unsigned NUM_RANKS = 4,
  parameter int unsigned CMD_GAP   = 2
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  // command request
  ddim_cmd_if.issuer                       cmd,
  // memory command pins
  output logic [NUM_RANKS-1:0]             o_cs_n,
  output logic                             o_ras_n,
  output logic                             o_cas_n,
  output logic                             o_we_n,
  output logic [ddim_pkg::BA_W-1:0]        o_ba,
  output logic [ddim_pkg::MA_W-1:0]        o_ma
);

  logic [7:0] gap_q;
  logic       take;

  assign cmd.ready = (gap_q == 8'h00);
  assign take      = cmd.valid && cmd.ready;

  // spacing between two commands
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      gap_q <= 8'h00;
    else if (take)
      gap_q <= 8'(CMD_GAP - 1);
    else if (gap_q != 8'h00)
      gap_q <= gap_q - 8'h01;
  end

  // one command cycle on all ranks, deselect otherwise
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cs_n                     <= '1;
      {o_ras_n, o_cas_n, o_we_n} <= ddim_pkg::PIN_NOP;
      o_ba                       <= '0;
      o_ma                       <= '0;
    end
    else if (take)
    begin
      o_cs_n <= '0;
      o_ba   <= cmd.ba;
      o_ma   <= cmd.ma;
      unique case (cmd.cmd)
        ddim_pkg::CMD_NOP:    {o_ras_n, o_cas_n, o_we_n} <= ddim_pkg::PIN_NOP;
        ddim_pkg::CMD_PREALL: {o_ras_n, o_cas_n, o_we_n} <= ddim_pkg::PIN_PRE;
        ddim_pkg::CMD_MRS,
        ddim_pkg::CMD_EMRS:   {o_ras_n, o_cas_n, o_we_n} <= ddim_pkg::PIN_MRS;
        ddim_pkg::CMD_SRE:    {o_ras_n, o_cas_n, o_we_n} <= ddim_pkg::PIN_SRE;
      endcase
    end
    else
    begin
      o_cs_n                     <= '1;
      {o_ras_n, o_cas_n, o_we_n} <= ddim_pkg::PIN_NOP;
    end
  end

endmodule // ddim_cmd_out

`default_nettype wire

// [ddim_wait_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module ddim_wait_timer #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  // control
  input  wire logic          i_load,
  input  wire logic [W-1:0]  i_count,
  output logic               o_busy
);

  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cnt_q <= '0;
    else if (i_load)
      cnt_q <= i_count;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - W'(1);
  end

  assign o_busy = (cnt_q != '0);

endmodule // ddim_wait_timer

`default_nettype wire

// [ddim_ctrl.sv]
// Operation
// RQ1: special command mode field clears to zero on leaving any reset.
// RQ2: while reset is active every CKE output is held low.
// RQ3: CKE stays low after reset until a nonzero mode is written, then rises.
// RQ4: suspend request flushes pending commands, then puts all ranks in self-refresh.
// RQ5: resume is a reset: mode clears, CKE low until nonzero mode write.
// RQ6: other low-power entry flushes pending commands and enters self-refresh.
// RQ7: leaving other low-power states exits self-refresh without software.
// RQ8: mode 001 turns each host memory cycle into a NOP command.
// RQ9: mode 010 turns each host memory cycle into precharge all banks.
// RQ10: mode 011 turns each host memory cycle into a mode register set.
// RQ11: mode 100 turns each host memory cycle into an extended mode register set.
// RQ12: host address bits map onto memory address lines to form the command.
// RQ13: read-only memory type field at bits 1:0 reads 10 for DDR2.
// RQ14: bit 31 of mode-one register selects standard or enhanced address map.
// RQ15: software steps NOP, precharge, mode programming, one access each, then normal.
`timescale 1ns/1ps
`default_nettype none

module ddim_ctrl #(
  parameter int unsigned NUM_RANKS     = 4,
  parameter int unsigned CMD_GAP       = 2,
  parameter int unsigned EXIT_WAIT_CYC = 200
) (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  // register port
  input  wire logic [ddim_pkg::REG_AW-1:0] i_reg_addr,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [31:0]                 i_reg_wdata,
  output logic [31:0]                      o_reg_rdata,
  // host memory cycles
  input  wire logic                        i_host_req,
  input  wire logic [31:0]                 i_host_addr,
  output logic                             o_host_ack,
  output logic                             o_norm_req,
  input  wire logic                        i_norm_idle,
  output logic                             o_enh_map,
  // power management
  input  wire logic                        i_suspend_req,
  input  wire logic                        i_lowpwr_req,
  output logic                             o_self_refresh,
  // memory pins
  output logic [NUM_RANKS-1:0]             o_cke,
  output logic [NUM_RANKS-1:0]             o_cs_n,
  output logic                             o_ras_n,
  output logic                             o_cas_n,
  output logic                             o_we_n,
  output logic [ddim_pkg::BA_W-1:0]        o_ba,
  output logic [ddim_pkg::MA_W-1:0]        o_ma
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  ddim_cmd_if cmd_if ();

  ddim_pkg::ddim_pwr_t                   pwr_q;
  ddim_pkg::ddim_pwr_t                   pwr_d;
  logic [2:0]                            scm_q;
  logic                                  cke_en_q;
  logic                                  enh_q;
  logic                                  susp_q;
  logic [7:0]                            rank_bnd0_q;
  logic [7:0]                            rank_bnd1_q;
  logic [7:0]                            rank_bnd2_q;
  logic [NUM_RANKS-1:0]                  cke_q;
  logic                                  sr_q;
  logic [31:0]                           rdata_q;
  logic                                  wr_mode0;
  logic                                  wr_nonzero;
  logic                                  special;
  logic                                  exit_go;
  logic                                  tmr_busy;
  logic                                  take;
  logic                                  cke_on;
  logic [ddim_pkg::BA_W+ddim_pkg::MA_W-1:0] mapped;
  logic [ddim_pkg::BA_W-1:0]             map_ba;
  logic [ddim_pkg::MA_W-1:0]             map_ma;
  logic [31:0]                           rd_word;

  assign wr_mode0   = i_reg_wr && (i_reg_addr == ddim_pkg::OFS_MODE_ZERO);
  assign wr_nonzero = wr_mode0 && (i_reg_wdata[ddim_pkg::SCM_MSB:ddim_pkg::SCM_LSB] != ddim_pkg::SCM_NORMAL);
  assign special    = (scm_q == ddim_pkg::SCM_NOP) || (scm_q == ddim_pkg::SCM_PREALL)
                   || (scm_q == ddim_pkg::SCM_MRS) || (scm_q == ddim_pkg::SCM_EMRS);
  assign take       = cmd_if.valid && cmd_if.ready;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      scm_q <= ddim_pkg::SCM_RST; // [RQ1] [RQ5]
    else if (wr_mode0)
      scm_q <= i_reg_wdata[ddim_pkg::SCM_MSB:ddim_pkg::SCM_LSB];
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      enh_q <= 1'b0;
    else if (i_reg_wr && (i_reg_addr == ddim_pkg::OFS_MODE_ONE))
      enh_q <= i_reg_wdata[ddim_pkg::ENH_BIT]; // [RQ14]
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rank_bnd0_q <= ddim_pkg::RANK_BND_RST;
      rank_bnd1_q <= ddim_pkg::RANK_BND_RST;
      rank_bnd2_q <= ddim_pkg::RANK_BND_RST;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == ddim_pkg::OFS_RANK_BND0)
        rank_bnd0_q <= i_reg_wdata[7:0];
      if (i_reg_addr == ddim_pkg::OFS_RANK_BND1)
        rank_bnd1_q <= i_reg_wdata[7:0];
      if (i_reg_addr == ddim_pkg::OFS_RANK_BND2)
        rank_bnd2_q <= i_reg_wdata[7:0];
    end
  end

  // read data, unmapped offsets and reserved bits read zero
  always_comb
  begin
    rd_word = '0;
    unique case (i_reg_addr)
      ddim_pkg::OFS_MODE_ZERO:
      begin
        rd_word[ddim_pkg::SCM_MSB:ddim_pkg::SCM_LSB]     = scm_q;
        rd_word[ddim_pkg::MTYPE_MSB:ddim_pkg::MTYPE_LSB] = ddim_pkg::MTYPE_DDR2; // [RQ13]
      end
      ddim_pkg::OFS_MODE_ONE:  rd_word[ddim_pkg::ENH_BIT] = enh_q;
      ddim_pkg::OFS_RANK_BND0: rd_word[7:0] = rank_bnd0_q;
      ddim_pkg::OFS_RANK_BND1: rd_word[7:0] = rank_bnd1_q;
      ddim_pkg::OFS_RANK_BND2: rd_word[7:0] = rank_bnd2_q;
      default:                 rd_word = '0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rdata_q <= '0;
    else if (i_reg_rd)
      rdata_q <= rd_word;
  end

  assign o_reg_rdata = rdata_q;
  assign o_enh_map   = enh_q;

  // ---------------------------------------------------------------------------
  // power sequencing
  // ---------------------------------------------------------------------------
  // suspend is only left through reset
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      susp_q <= 1'b0;
    else if (i_suspend_req)
      susp_q <= 1'b1; // [RQ5]
  end

  assign exit_go = (pwr_q == ddim_pkg::PW_SR) && !susp_q && !i_lowpwr_req;

  always_comb
  begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      ddim_pkg::PW_RUN:
        if (i_suspend_req || i_lowpwr_req)
          pwr_d = ddim_pkg::PW_FLUSH; // [RQ4] [RQ6]
      ddim_pkg::PW_FLUSH:
        if (cmd_if.ready && i_norm_idle)
          pwr_d = ddim_pkg::PW_SRE; // [RQ4] [RQ6]
      ddim_pkg::PW_SRE:
        if (!cke_en_q || take)
          pwr_d = ddim_pkg::PW_SR;
      ddim_pkg::PW_SR:
        if (exit_go)
          pwr_d = ddim_pkg::PW_EXIT; // [RQ7]
      ddim_pkg::PW_EXIT:
        if (!tmr_busy)
          pwr_d = ddim_pkg::PW_RUN; // [RQ7]
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      pwr_q <= ddim_pkg::PW_RUN;
    else
      pwr_q <= pwr_d;
  end

  ddim_wait_timer #(
    .W        (16)
  ) u_exit_timer (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_load    (exit_go),
    .i_count   (16'(EXIT_WAIT_CYC)),
    .o_busy    (tmr_busy)
  );

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      sr_q <= 1'b0;
    else
      sr_q <= (pwr_d == ddim_pkg::PW_SR);
  end

  assign o_self_refresh = sr_q;

  // ---------------------------------------------------------------------------
  // clock enable
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cke_en_q <= 1'b0; // [RQ3] [RQ5]
    else if (wr_nonzero)
      cke_en_q <= 1'b1; // [RQ3]
  end

  // low through self-refresh, dropped together with the entry command
  assign cke_on = (cke_en_q || wr_nonzero) && (pwr_q != ddim_pkg::PW_SR)
               && !((pwr_q == ddim_pkg::PW_SRE) && take);

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      cke_q <= '0; // [RQ2]
    else
      cke_q <= {NUM_RANKS{cke_on}}; // [RQ3] [RQ7]
  end

  assign o_cke = cke_q;

  // ---------------------------------------------------------------------------
  // host cycle conversion
  // ---------------------------------------------------------------------------
  assign mapped = ddim_pkg::ddim_map_addr(i_host_addr, enh_q); // [RQ12]
  assign map_ma = mapped[ddim_pkg::MA_W-1:0];
  assign map_ba = mapped[ddim_pkg::BA_W+ddim_pkg::MA_W-1:ddim_pkg::MA_W];

  always_comb
  begin
    cmd_if.valid = 1'b0;
    cmd_if.cmd   = ddim_pkg::CMD_NOP;
    cmd_if.ba    = '0;
    cmd_if.ma    = '0;
    o_host_ack   = 1'b0;
    o_norm_req   = 1'b0;
    unique case (pwr_q)
      ddim_pkg::PW_RUN:
        if (i_host_req && special)
        begin
          cmd_if.valid = 1'b1;
          o_host_ack   = cmd_if.ready;
          unique case (scm_q)
            ddim_pkg::SCM_NOP:
              cmd_if.cmd = ddim_pkg::CMD_NOP; // [RQ8]
            ddim_pkg::SCM_PREALL:
            begin
              cmd_if.cmd                  = ddim_pkg::CMD_PREALL; // [RQ9]
              cmd_if.ma[ddim_pkg::AP_BIT] = 1'b1;
            end
            ddim_pkg::SCM_MRS:
            begin
              cmd_if.cmd = ddim_pkg::CMD_MRS; // [RQ10]
              cmd_if.ba  = ddim_pkg::BA_MR;
              cmd_if.ma  = map_ma; // [RQ12]
            end
            default:
            begin
              cmd_if.cmd = ddim_pkg::CMD_EMRS; // [RQ11]
              cmd_if.ba  = (map_ba == ddim_pkg::BA_MR) ? ddim_pkg::BA_EMR1 : map_ba;
              cmd_if.ma  = map_ma; // [RQ12]
            end
          endcase
        end
        else
          o_norm_req = i_host_req;
      ddim_pkg::PW_SRE:
      begin
        cmd_if.valid = cke_en_q; // [RQ4] [RQ6]
        cmd_if.cmd   = ddim_pkg::CMD_SRE;
      end
      ddim_pkg::PW_FLUSH,
      ddim_pkg::PW_SR,
      ddim_pkg::PW_EXIT:
        cmd_if.valid = 1'b0;
    endcase
  end

  ddim_cmd_out #(
    .NUM_RANKS (NUM_RANKS),
    .CMD_GAP   (CMD_GAP)
  ) u_cmd_out (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .cmd       (cmd_if.issuer),
    .o_cs_n    (o_cs_n),
    .o_ras_n   (o_ras_n),
    .o_cas_n   (o_cas_n),
    .o_we_n    (o_we_n),
    .o_ba      (o_ba),
    .o_ma      (o_ma)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  logic first_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_cmd_pins(logic [2:0] code);
    (o_cs_n == '0) && ({o_ras_n, o_cas_n, o_we_n} == code);
  endsequence

  sequence s_sr_enter;
    (pwr_q == ddim_pkg::PW_SRE) ##1 (pwr_q == ddim_pkg::PW_SR && o_cke == '0 && o_self_refresh);
  endsequence

  property p_scm_reset;
    first_q |-> (scm_q == ddim_pkg::SCM_NORMAL);
  endproperty
  a_scm_reset: assert property (p_scm_reset) else $error("mode field not clear after reset"); // [RQ1]

  property p_cke_reset;
    first_q |-> (o_cke == '0);
  endproperty
  a_cke_reset: assert property (p_cke_reset) else $error("cke high after reset"); // [RQ2]

  property p_cke_cause;
    $rose(o_cke[0]) |-> $past(cke_en_q || wr_nonzero);
  endproperty
  a_cke_cause: assert property (p_cke_cause) else $error("cke rose without nonzero mode write"); // [RQ3]

  property p_cke_on_write;
    (wr_nonzero && pwr_q == ddim_pkg::PW_RUN) |=> (o_cke == '1);
  endproperty
  a_cke_on_write: assert property (p_cke_on_write) else $error("cke not raised by mode write"); // [RQ3]

  property p_susp_flush;
    (pwr_q == ddim_pkg::PW_RUN && i_suspend_req) |=> (pwr_q == ddim_pkg::PW_FLUSH);
  endproperty
  a_susp_flush: assert property (p_susp_flush) else $error("suspend did not start flush"); // [RQ4]

  property p_flush_sr;
    (pwr_q == ddim_pkg::PW_FLUSH && cmd_if.ready && i_norm_idle && cke_en_q) |=> s_sr_enter;
  endproperty
  a_flush_sr: assert property (p_flush_sr) else $error("self-refresh entry missing"); // [RQ4]

  property p_susp_hold;
    (susp_q && pwr_q == ddim_pkg::PW_SR) |=> (pwr_q == ddim_pkg::PW_SR);
  endproperty
  a_susp_hold: assert property (p_susp_hold) else $error("left suspend without reset"); // [RQ5]

  property p_lowpwr_flush;
    (pwr_q == ddim_pkg::PW_RUN && i_lowpwr_req) |=> (pwr_q == ddim_pkg::PW_FLUSH);
  endproperty
  a_lowpwr_flush: assert property (p_lowpwr_flush) else $error("low-power entry did not flush"); // [RQ6]

  property p_lowpwr_exit;
    exit_go |=> (pwr_q == ddim_pkg::PW_EXIT) ##[1:1000] (pwr_q == ddim_pkg::PW_RUN);
  endproperty
  a_lowpwr_exit: assert property (p_lowpwr_exit) else $error("self-refresh exit stalled"); // [RQ7]

  property p_nop;
    (o_host_ack && scm_q == ddim_pkg::SCM_NOP) |=> s_cmd_pins(ddim_pkg::PIN_NOP);
  endproperty
  a_nop: assert property (p_nop) else $error("nop command missing"); // [RQ8]

  property p_preall;
    (o_host_ack && scm_q == ddim_pkg::SCM_PREALL) |=> s_cmd_pins(ddim_pkg::PIN_PRE) and o_ma[ddim_pkg::AP_BIT];
  endproperty
  a_preall: assert property (p_preall) else $error("precharge all missing"); // [RQ9]

  property p_mrs;
    (o_host_ack && scm_q == ddim_pkg::SCM_MRS) |=> s_cmd_pins(ddim_pkg::PIN_MRS) and (o_ba == ddim_pkg::BA_MR);
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode register set missing"); // [RQ10]

  property p_emrs;
    (o_host_ack && scm_q == ddim_pkg::SCM_EMRS) |=> s_cmd_pins(ddim_pkg::PIN_MRS) and (o_ba != ddim_pkg::BA_MR);
  endproperty
  a_emrs: assert property (p_emrs) else $error("extended mode register set missing"); // [RQ11]

  property p_map;
    (o_host_ack && scm_q == ddim_pkg::SCM_MRS) |=> (o_ma == $past(map_ma));
  endproperty
  a_map: assert property (p_map) else $error("mode address not taken from host address"); // [RQ12]

  property p_dtype;
    (i_reg_rd && i_reg_addr == ddim_pkg::OFS_MODE_ZERO)
      |=> (o_reg_rdata[ddim_pkg::MTYPE_MSB:ddim_pkg::MTYPE_LSB] == ddim_pkg::MTYPE_DDR2);
  endproperty
  a_dtype: assert property (p_dtype) else $error("memory type field wrong"); // [RQ13]

  property p_enh;
    (i_reg_wr && i_reg_addr == ddim_pkg::OFS_MODE_ONE) |=> (o_enh_map == $past(i_reg_wdata[ddim_pkg::ENH_BIT]));
  endproperty
  a_enh: assert property (p_enh) else $error("enhanced map bit not stored"); // [RQ14]

endmodule // ddim_ctrl

`default_nettype wire

// [ddim_rank_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ddim_rank_model (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  // memory pins
  input  wire logic [3:0]                  i_cs_n,
  input  wire logic                        i_ras_n,
  input  wire logic                        i_cas_n,
  input  wire logic                        i_we_n,
  input  wire logic [ddim_pkg::BA_W-1:0]   i_ba,
  input  wire logic [ddim_pkg::MA_W-1:0]   i_ma,
  // last command seen
  output logic [2:0]                       o_cmd,
  output logic [ddim_pkg::BA_W-1:0]        o_ba,
  output logic [ddim_pkg::MA_W-1:0]        o_ma,
  output logic [7:0]                       o_count
);
  // ---------------------------------------------------------------------------
  // capture of commands aimed at every rank
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_cmd   <= 3'h7;
      o_ba    <= '0;
      o_ma    <= '0;
      o_count <= 8'h00;
    end
    else if (i_cs_n == 4'h0)
    begin
      o_cmd   <= {i_ras_n, i_cas_n, i_we_n};
      o_ba    <= i_ba;
      o_ma    <= i_ma;
      o_count <= o_count + 8'h01;
    end
  end
endmodule // ddim_rank_model

`default_nettype wire

// [ddim_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module ddim_ctrl_tb;
  logic        clk, rst_n, reg_wr, reg_rd, host_req, suspend, lowpwr, idle;
  logic        host_ack, norm_req, enh_map, self_ref, ras_n, cas_n, we_n;
  logic [11:0] reg_addr;
  logic [31:0] wdata, rdata, host_addr;
  logic [3:0]  cke, cs_n;
  logic [1:0]  ba, mdl_ba;
  logic [13:0] ma, mdl_ma;
  logic [2:0]  mdl_cmd;
  logic [7:0]  mdl_cnt, cnt;
  int          fail_count, check_count;

  ddim_ctrl #(.EXIT_WAIT_CYC(4)) ddim_ctrl_inst (.i_clk(clk), .i_reset_n(rst_n), .i_reg_addr(reg_addr),
    .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_host_req(host_req),
    .i_host_addr(host_addr), .o_host_ack(host_ack), .o_norm_req(norm_req), .i_norm_idle(idle),
    .o_enh_map(enh_map), .i_suspend_req(suspend), .i_lowpwr_req(lowpwr), .o_self_refresh(self_ref),
    .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_ma(ma));
  ddim_rank_model ddim_rank_model_inst (.i_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_ma(ma), .o_cmd(mdl_cmd), .o_ba(mdl_ba), .o_ma(mdl_ma),
    .o_count(mdl_cnt));

  // ---------------------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(rdata, exp);
  endtask

  task automatic host(input logic [31:0] a);
    int n;
    @(negedge clk);
    host_req = 1'b1;
    host_addr = a;
    n = 0;
    #1;
    while (host_ack !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk(32'(n < 20), 32'h1);
    @(negedge clk);
    host_req = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  task automatic wait_sr(input logic v);
    int n;
    n = 0;
    while (self_ref !== v && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk(32'(self_ref), 32'(v));
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    chk(32'(cke), 32'h0);
    @(negedge clk);
    rst_n = 1'b1;
  endtask

  task automatic wrap_up();
    $display("mismatches=%0d checks=%0d", fail_count, check_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end

  initial
  begin
    {rst_n, reg_wr, reg_rd, host_req, suspend, lowpwr, reg_addr, wdata, host_addr} = '0;
    idle = 1'b1;
    fail_count = 0;
    check_count = 0;
    do_reset();
    rd_chk(12'h100, 32'h2);
    rd_chk(12'h124, 32'h0);
    rd_chk(12'h200, 32'h0);
    wr(12'h181, 32'ha5);
    rd_chk(12'h181, 32'ha5);
    wr(12'h100, 32'h3);
    rd_chk(12'h100, 32'h2);
    chk(32'(cke), 32'h0);
    for (int m = 1; m <= 4; m++)
    begin
      cnt = mdl_cnt;
      wr(12'h100, 32'(m) << 4);
      chk(32'(cke), 32'hf);
      host(32'h1230);
      chk(32'(mdl_cnt), 32'(cnt + 8'h01));
      chk(32'(mdl_cmd), 32'(m == 1 ? ddim_pkg::PIN_NOP : m == 2 ? ddim_pkg::PIN_PRE : ddim_pkg::PIN_MRS));
      if (m > 1)
        chk(32'({mdl_ba, mdl_ma}), {16'h0, m == 4 ? 2'h1 : 2'h0, m == 2 ? 14'h400 : 14'h246});
    end
    wr(12'h124, 32'h8000_0000);
    chk(32'(enh_map), 32'h1);
    rd_chk(12'h124, 32'h8000_0000);
    wr(12'h100, 32'h30);
    host(32'h1230);
    chk(32'(mdl_ma), 32'h123);
    wr(12'h100, 32'h0);
    @(negedge clk);
    host_req = 1'b1;
    #1;
    chk(32'({norm_req, host_ack}), 32'h2);
    @(negedge clk);
    {host_req, idle, lowpwr} = 3'b001;
    repeat (4) @(negedge clk);
    chk(32'(self_ref), 32'h0);
    idle = 1'b1;
    wait_sr(1'b1);
    @(negedge clk);
    chk(32'({cke, mdl_cmd}), 32'(ddim_pkg::PIN_SRE));
    lowpwr = 1'b0;
    wait_sr(1'b0);
    repeat (2) @(negedge clk);
    chk(32'(cke), 32'hf);
    repeat (8) @(negedge clk);
    suspend = 1'b1;
    @(negedge clk);
    suspend = 1'b0;
    wait_sr(1'b1);
    @(negedge clk);
    chk(32'({cke, mdl_cmd}), 32'(ddim_pkg::PIN_SRE));
    do_reset();
    rd_chk(12'h100, 32'h2);
    chk(32'(cke), 32'h0);
    wrap_up();
  end
endmodule // ddim_ctrl_tb

`default_nettype wire
